/* File: hw/bff_defs.svh */
// bff_defs.svh: offsets, codes and reset values of the broadcast frame filter
// assumes inclusion wherever the macros are used; the guard keeps it single
`ifndef BFF_DEFS_SVH
`define BFF_DEFS_SVH
// register byte offsets on the axi4-lite bus
`define BFF_ADDR_CMD 8'h00
`define BFF_ADDR_ARG0 8'h04
`define BFF_ADDR_ARG1 8'h08
`define BFF_ADDR_RSP 8'h0c
`define BFF_ADDR_RTYPE 8'h10
`define BFF_ADDR_SET 8'h14
`define BFF_ADDR_STAT 8'h18
// command and response type codes
`define BFF_CMD_SET_MAC 8'h0e
`define BFF_CMD_EN_BC 8'h10
`define BFF_CMD_DIS_BC 8'h11
`define BFF_RSP_FLAG 8'h80
// response and reason codes
`define BFF_RC_OK 16'h0000
`define BFF_RC_FAIL 16'h0001
`define BFF_RC_UNSUP 16'h0002
`define BFF_RS_NONE 16'h0000
`define BFF_RS_MAC_ZERO 16'h0e08
`define BFF_RS_UNK_CMD 16'h7fff
// status field positions
`define BFF_ST_ACTIVE 0
`define BFF_ST_CAP_LSB 8
// class bit positions in the settings word
`define BFF_BIT_ARP 0
`define BFF_BIT_DHCPC 1
`define BFF_BIT_DHCPS 2
`define BFF_BIT_NBIOS 3
// supported classes; arp always present
`define BFF_CAP_CLASSES 4'hf
// frame match values
`define BFF_MAC_BCAST 48'hffffffffffff
`define BFF_ET_ARP 16'h0806
`define BFF_ET_IPV4 16'h0800
`define BFF_PROTO_UDP 8'h11
`define BFF_PORT_DHCPC 16'h0044
`define BFF_PORT_DHCPS 16'h0043
`define BFF_PORT_NBNS 16'h0089
`define BFF_PORT_NBDG 16'h008a
// reset values
`define BFF_RST_SET 4'h0
`define BFF_RST_ACTIVE 1'b0
// axi responses
`define BFF_AXI_OKAY 2'h0
`define BFF_AXI_SLVERR 2'h2
`endif

/* File: hw/bff_pkg.sv */
// bff_pkg: types of the broadcast frame filter
// assumes bff_defs.svh on the include path
`include "bff_defs.svh"
package bff_pkg;
  // parsed header fields of one received frame
  typedef struct packed {
    logic [47:0] dst_mac;
    logic [15:0] ethertype;
    logic [7:0] ip_proto;
    logic [15:0] udp_dport;
  } bff_frame_t;
  // response as carried back to the management controller
  typedef struct packed {
    logic [7:0] rsp_type;
    logic [15:0] rsp_code;
    logic [15:0] reason;
  } bff_rsp_t;
  typedef enum logic [7:0] {
    BFF_CMD_SET_MAC = `BFF_CMD_SET_MAC,
    BFF_CMD_EN_BC = `BFF_CMD_EN_BC,
    BFF_CMD_DIS_BC = `BFF_CMD_DIS_BC
  } bff_cmd_t;
endpackage : bff_pkg

/* File: hw/bff_filter.sv */
// bff_filter: broadcast frame filter with command decode over axi4-lite
// assumes frame descriptors come from parser logic on the same clock
// Operation
// R01 - set mac command with all-zero address answers reason code 0x0e08
// R02 - response word holds response code high, reason code low
// R03 - command type 0x10 enables broadcast filtering
// R04 - once enabled, broadcasts pass or drop per class settings
// R05 - no class selected means every broadcast is dropped
// R06 - settings word is taken from payload bytes 16 to 19
// R07 - class bit one forwards matching frames, zero discards them
// R08 - bit 0: all-ones destination and ethertype 0x0806
// R09 - arp class is always implemented
// R10 - bit 1: ipv4, udp, destination port 68
// R11 - bit 2: ipv4, udp, destination port 67
// R12 - bit 3: ipv4, udp, destination port 137 or 138
// R13 - unsupported classes are blocked; controller writes them zero
// R14 - supported classes are reported in the capability field
// R15 - controller sets only the classes it wants forwarded
// R16 - enable command is always accepted and answered
// R17 - enable command response carries type code 0x90
// R18 - reserved bits 4 to 31 ignored; non-broadcasts unaffected
// R19 - latest accepted settings hold until new settings arrive
`timescale 1ns/1ps
`include "bff_defs.svh"
module bff_filter
  import bff_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_ce,
  // axi4-lite slave
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // frame decision stream
  input wire logic i_frm_valid,
  input wire bff_frame_t i_frm,
  output logic o_dec_valid,
  output logic o_dec_fwd,
  output logic o_dec_bcast
);

  ////////////////////////////////////////////////////////////////////////
  // state
  // all registers freeze together while the clock enable is low
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] cmd_reg, cmd_next;
  logic [31:0] arg0_reg, arg0_next;
  logic [31:0] arg1_reg, arg1_next;
  bff_rsp_t rsp_reg, rsp_next;
  logic [3:0] set_reg, set_next;
  logic active_reg, active_next;
  logic dec_valid_reg, dec_valid_next;
  logic dec_fwd_reg, dec_fwd_next;
  logic dec_bcast_reg, dec_bcast_next;

  // classes actually built; arp cannot be dropped from the set
  // trade-off: every optional class is built, so none is ever refused
  localparam logic [3:0] CAP = `BFF_CAP_CLASSES | 4'h1; // R09

  // merge a write into a stored word under byte strobes
  function automatic logic [31:0] bff_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction : bff_merge

  ////////////////////////////////////////////////////////////////////////
  // bus handshakes: each channel ready until its item is held
  // ready is a pure decode of flops, so it never depends on valid
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready = !w_held_reg && !bvalid_reg;
  assign o_arready = !rvalid_reg;
  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;
  assign o_rvalid = rvalid_reg;
  assign o_rresp = rresp_reg;
  assign o_rdata = rdata_reg;
  assign o_dec_valid = dec_valid_reg;
  assign o_dec_fwd = dec_fwd_reg;
  assign o_dec_bcast = dec_bcast_reg;

  ////////////////////////////////////////////////////////////////////////
  // register file and command execution, next values
  always_comb begin
    logic [31:0] wd;
    logic [7:0] ctype;
    wd = 32'h0;
    ctype = 8'h00;
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    cmd_next = cmd_reg;
    arg0_next = arg0_reg;
    arg1_next = arg1_reg;
    rsp_next = rsp_reg;
    set_next = set_reg;
    active_next = active_reg;
    // address and data may arrive in either order
    if (i_awvalid && o_awready) begin
      aw_held_next = 1'b1;
      awaddr_next = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      w_held_next = 1'b1;
      wdata_next = i_wdata;
      wstrb_next = i_wstrb;
    end
    if (bvalid_reg && i_bready) begin
      bvalid_next = 1'b0;
    end
    // write executes one cycle after both halves are held
    // halves drop in the edge that raises the answer, so no second write slips in
    if (aw_held_reg && w_held_reg && !bvalid_reg) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `BFF_AXI_OKAY;
      wd = bff_merge(32'h0, wdata_reg, wstrb_reg);
      case (awaddr_reg)
        `BFF_ADDR_ARG0: arg0_next = bff_merge(arg0_reg, wdata_reg, wstrb_reg);
        `BFF_ADDR_ARG1: arg1_next = bff_merge(arg1_reg, wdata_reg, wstrb_reg);
        `BFF_ADDR_CMD: begin
          // writing the command register runs the command at once
          ctype = wd[7:0];
          cmd_next = ctype;
          rsp_next.rsp_type = ctype | `BFF_RSP_FLAG; // R17
          rsp_next.rsp_code = `BFF_RC_OK;
          rsp_next.reason = `BFF_RS_NONE;
          case (ctype)
            BFF_CMD_EN_BC: begin // R03
              // always accepted; unsupported and reserved bits forced low
              set_next = arg0_reg[3:0] & CAP; // R06 R13 R18 R19 R16
              active_next = 1'b1; // R04
            end
            BFF_CMD_DIS_BC: begin
              active_next = 1'b0;
            end
            BFF_CMD_SET_MAC: begin
              // address table lives elsewhere; only the zero check is here
              if ({arg0_reg, arg1_reg[31:16]} == 48'h0) begin
                rsp_next.rsp_code = `BFF_RC_FAIL;
                rsp_next.reason = `BFF_RS_MAC_ZERO; // R01
              end
            end
            default: begin
              rsp_next.rsp_code = `BFF_RC_UNSUP;
              rsp_next.reason = `BFF_RS_UNK_CMD;
            end
          endcase
        end
        `BFF_ADDR_RSP, `BFF_ADDR_RTYPE, `BFF_ADDR_SET, `BFF_ADDR_STAT: begin
          // read-only words, write ignored
        end
        default: bresp_next = `BFF_AXI_SLVERR;
      endcase
    end
    // read channel
    // data captured with the address and held until rready, no read-ahead
    if (rvalid_reg && i_rready) begin
      rvalid_next = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      rvalid_next = 1'b1;
      rresp_next = `BFF_AXI_OKAY;
      case (i_araddr)
        `BFF_ADDR_CMD: rdata_next = {24'h0, cmd_reg};
        `BFF_ADDR_ARG0: rdata_next = arg0_reg;
        `BFF_ADDR_ARG1: rdata_next = arg1_reg;
        `BFF_ADDR_RSP: rdata_next = {rsp_reg.rsp_code, rsp_reg.reason}; // R02
        `BFF_ADDR_RTYPE: rdata_next = {24'h0, rsp_reg.rsp_type};
        `BFF_ADDR_SET: rdata_next = {28'h0, set_reg};
        `BFF_ADDR_STAT: begin
          rdata_next = 32'h0;
          rdata_next[`BFF_ST_ACTIVE] = active_reg;
          rdata_next[`BFF_ST_CAP_LSB +: 4] = CAP; // R14
        end
        default: begin
          rdata_next = 32'h0;
          rresp_next = `BFF_AXI_SLVERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register file and command execution, flops
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `BFF_AXI_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= `BFF_AXI_OKAY;
      rdata_reg <= 32'h0;
      cmd_reg <= 8'h00;
      arg0_reg <= 32'h0;
      arg1_reg <= 32'h0;
      rsp_reg <= '0;
      set_reg <= `BFF_RST_SET;
      active_reg <= `BFF_RST_ACTIVE;
    end else if (i_ce) begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      cmd_reg <= cmd_next;
      arg0_reg <= arg0_next;
      arg1_reg <= arg1_next;
      rsp_reg <= rsp_next;
      set_reg <= set_next;
      active_reg <= active_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame classification, next values
  // broadcast test gates every class, so a unicast arp frame never counts
  always_comb begin
    logic bcast;
    logic udp4;
    logic [3:0] hit;
    bcast = (i_frm.dst_mac == `BFF_MAC_BCAST);
    udp4 = (i_frm.ethertype == `BFF_ET_IPV4) && (i_frm.ip_proto == `BFF_PROTO_UDP);
    hit = 4'h0;
    hit[`BFF_BIT_ARP] = (i_frm.ethertype == `BFF_ET_ARP); // R08
    hit[`BFF_BIT_DHCPC] = udp4 && (i_frm.udp_dport == `BFF_PORT_DHCPC); // R10
    hit[`BFF_BIT_DHCPS] = udp4 && (i_frm.udp_dport == `BFF_PORT_DHCPS); // R11
    hit[`BFF_BIT_NBIOS] = udp4 && ((i_frm.udp_dport == `BFF_PORT_NBNS) ||
                                   (i_frm.udp_dport == `BFF_PORT_NBDG)); // R12
    dec_valid_next = i_frm_valid;
    dec_bcast_next = i_frm_valid ? bcast : dec_bcast_reg;
    dec_fwd_next = dec_fwd_reg;
    if (i_frm_valid) begin
      if (!bcast || !active_reg) begin
        dec_fwd_next = 1'b1; // R18
      end else begin
        // empty settings word yields no hit, so every broadcast drops
        dec_fwd_next = |(hit & set_reg); // R04 R05 R07 R19
      end
    end
  end

  // frame classification, flops
  // pulse and fields share one enable, so a frozen cycle keeps them aligned
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      dec_valid_reg <= 1'b0;
      dec_fwd_reg <= 1'b0;
      dec_bcast_reg <= 1'b0;
    end else if (i_ce) begin
      dec_valid_reg <= dec_valid_next;
      dec_fwd_reg <= dec_fwd_next;
      dec_bcast_reg <= dec_bcast_next;
    end
  end

endmodule : bff_filter

/* File: testbench/bff_filter_chk.sv */
// bff_filter_chk: port-level assertions for the broadcast frame filter
// assumes bind onto bff_filter, i_ce held high
`timescale 1ns/1ps
`include "bff_defs.svh"
module bff_filter_chk
  import bff_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic i_frm_valid,
  input wire bff_frame_t i_frm,
  input wire logic o_dec_valid,
  input wire logic o_dec_fwd,
  input wire logic o_dec_bcast
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////
  // frame decisions, one cycle after the descriptor
  sequence s_bc;
    i_frm_valid && i_frm.dst_mac == `BFF_MAC_BCAST;
  endsequence
  sequence s_nb;
    i_frm_valid && i_frm.dst_mac != `BFF_MAC_BCAST;
  endsequence
  property p_bc; s_bc |=> o_dec_valid && o_dec_bcast; endproperty
  a_bc: assert property (p_bc) else $error("broadcast flag missing");
  property p_nb; s_nb |=> o_dec_valid && o_dec_fwd && !o_dec_bcast; endproperty
  a_nb: assert property (p_nb) else $error("non-broadcast not forwarded");
  property p_pulse; !i_frm_valid |=> !o_dec_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("decision without frame");
  property p_hold; !i_frm_valid |=> $stable(o_dec_fwd) && $stable(o_dec_bcast); endproperty
  a_hold: assert property (p_hold) else $error("decision changed between frames");
  ////////////////////////////////////////////////////////////
  // command bus answers; a stuck answer would hide every response
  property p_wans; i_awvalid && o_awready && i_wvalid && o_wready |-> ##[1:2] o_bvalid; endproperty
  a_wans: assert property (p_wans) else $error("write not answered");
  property p_rans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_unmap; i_arvalid && o_arready && i_araddr > `BFF_ADDR_STAT |=> o_rresp == `BFF_AXI_SLVERR && o_rdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  property p_brdy; o_bvalid |-> !o_awready && !o_wready; endproperty
  a_brdy: assert property (p_brdy) else $error("write taken while answering");
  property p_rrdy; o_rvalid |-> !o_arready; endproperty
  a_rrdy: assert property (p_rrdy) else $error("read taken while answering");
endmodule : bff_filter_chk

/* File: testbench/bff_mc.sv */
// bff_mc: management controller model, axi4-lite master with write and read tasks
// assumes bready and rready may stay high, answers checked by the bench
`timescale 1ns/1ps
module bff_mc (
  input wire logic i_clk_sys,
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic i_bvalid,
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic i_rvalid
);
  // idle master; ready is sampled mid-cycle, when it has settled
  initial begin
    o_awaddr = 8'h00; o_awvalid = 1'b0; o_wdata = 32'h0; o_wvalid = 1'b0;
    o_araddr = 8'h00; o_arvalid = 1'b0;
  end
  // one register write; command type 0x10 in byte 0 of the command word starts the filter
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    @(posedge i_clk_sys);
    o_awaddr <= a; o_wdata <= d; o_awvalid <= 1'b1; o_wvalid <= 1'b1;
    pa = 1'b1; pw = 1'b1;
    while (pa || pw) begin
      @(negedge i_clk_sys); ta = pa && i_awready; tw = pw && i_wready;
      @(posedge i_clk_sys);
      if (ta) begin o_awvalid <= 1'b0; pa = 1'b0; end
      if (tw) begin o_wvalid <= 1'b0; pw = 1'b0; end
    end
    do begin @(negedge i_clk_sys); ta = i_bvalid; @(posedge i_clk_sys); end while (!ta);
  endtask : wr
  // one read; data is judged by the bench at the rvalid edge
  task rd(input logic [7:0] a);
    logic t;
    @(posedge i_clk_sys);
    o_araddr <= a; o_arvalid <= 1'b1;
    do begin @(negedge i_clk_sys); t = i_arready; @(posedge i_clk_sys); end while (!t);
    o_arvalid <= 1'b0;
    do begin @(negedge i_clk_sys); t = i_rvalid; @(posedge i_clk_sys); end while (!t);
  endtask : rd
endmodule : bff_mc

/* File: testbench/testbench.sv */
// testbench: commands over axi4-lite, frames in, decisions scored from queues
// assumes bff_pkg compiled first, bff_mc drives the register bus
`timescale 1ns/1ps
`include "bff_defs.svh"
`define CHK(n, e, g) begin checked++; if ((e) !== (g)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module testbench
  import bff_pkg::*;
;
  logic c, i_nrst, i_frm_valid, awv, wv, arv, awr, wr_, bv, arr, rv, dv, df, db;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, s, r;
  logic [1:0] bresp, rresp;
  bff_frame_t i_frm;
  logic [1:0] q_f[$];
  logic [1:0] q_b[$];
  logic [33:0] q_r[$];
  logic [1:0] ef, eb;
  logic [33:0] er;
  logic [15:0] pt[6] = '{16'h0000, 16'h0044, 16'h0043, 16'h0089, 16'h008a, 16'h0045};
  int cl[6] = '{0, 1, 2, 3, 3, 9};
  int fail_count = 0, checked = 0, cyc = 0;
  bff_mc bff_mc_inst (.i_clk_sys(c), .o_awaddr(awa), .o_awvalid(awv), .i_awready(awr), .o_wdata(wd),
    .o_wvalid(wv), .i_wready(wr_), .i_bvalid(bv), .o_araddr(ara), .o_arvalid(arv), .i_arready(arr), .i_rvalid(rv));
  bff_filter bff_filter_inst (.i_clk_sys(c), .i_nrst(i_nrst), .i_ce(1'b1), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr_), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(1'b1), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rv), .i_rready(1'b1), .i_frm_valid(i_frm_valid), .i_frm(i_frm), .o_dec_valid(dv), .o_dec_fwd(df),
    .o_dec_bcast(db));
  ////////////////////////////////////////////////////////////
  // clock, 100 ns period
  initial begin c = 1'b0; forever #50 c = ~c; end
  function logic [31:0] xs();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5;
    return s;
  endfunction : xs
  task summarize();
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  // scoreboard: oldest note against each answer as it appears
  always @(posedge c) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end else begin
      // each note is taken off once, before the compare uses it
      if (dv) begin
        ef = q_f.pop_front();
        `CHK("bcast_fwd", ef, {db, df})
      end
      if (bv) begin
        eb = q_b.pop_front();
        `CHK("bresp", eb, bresp)
      end
      if (rv) begin
        er = q_r.pop_front();
        `CHK("rdata", er, {rresp, rdata})
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // drivers that note what they expect
  task wc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    q_b.push_back(e); bff_mc_inst.wr(a, d);
  endtask : wc
  task rc(input logic [7:0] a, input logic [33:0] e);
    q_r.push_back(e); bff_mc_inst.rd(a);
  endtask : rc
  task frm(input bff_frame_t f, input logic e);
    @(posedge c); i_frm_valid <= 1'b1; i_frm <= f; q_f.push_back({f.dst_mac == `BFF_MAC_BCAST, e});
    @(posedge c); i_frm_valid <= 1'b0;
  endtask : frm
  function bff_frame_t fr(int j);
    return {`BFF_MAC_BCAST, j == 0 ? `BFF_ET_ARP : `BFF_ET_IPV4, `BFF_PROTO_UDP, pt[j]};
  endfunction : fr
  task en(input logic [31:0] v);
    wc(`BFF_ADDR_ARG0, v, `BFF_AXI_OKAY); wc(`BFF_ADDR_CMD, 32'h10, `BFF_AXI_OKAY);
  endtask : en
  // main sequence
  initial begin
    s = 32'h93d2; i_nrst = 1'b0; i_frm_valid = 1'b0; i_frm = '0;
    repeat (2) @(posedge c);
    i_nrst <= 1'b1;
    rc(`BFF_ADDR_STAT, 34'h000000f00);
    for (int j = 0; j < 6; j++) frm(fr(j), 1'b1);
    en(32'h0);
    rc(`BFF_ADDR_RSP, 34'h0);
    rc(`BFF_ADDR_RTYPE, 34'h90);
    rc(`BFF_ADDR_STAT, 34'h000000f01);
    for (int j = 0; j < 6; j++) frm(fr(j), 1'b0);
    for (int k = 0; k < 4; k++) begin
      r = xs();
      en((r & 32'hfffffff0) | (32'h1 << k));
      rc(`BFF_ADDR_SET, {2'h0, 32'h1 << k});
      for (int j = 0; j < 6; j++) frm(fr(j), cl[j] == k);
      frm({16'h0200, xs(), 40'h0}, 1'b1);
    end
    wc(`BFF_ADDR_ARG0, 32'h0, `BFF_AXI_OKAY); wc(`BFF_ADDR_ARG1, 32'h0, `BFF_AXI_OKAY);
    wc(`BFF_ADDR_CMD, 32'h0e, `BFF_AXI_OKAY);
    rc(`BFF_ADDR_RSP, {2'h0, `BFF_RC_FAIL, `BFF_RS_MAC_ZERO});
    frm(fr(4), 1'b1);
    frm(fr(0), 1'b0);
    wc(`BFF_ADDR_ARG0, xs() | 32'h1, `BFF_AXI_OKAY); wc(`BFF_ADDR_CMD, 32'h0e, `BFF_AXI_OKAY);
    rc(`BFF_ADDR_RSP, 34'h0);
    wc(`BFF_ADDR_CMD, 32'h55, `BFF_AXI_OKAY);
    rc(`BFF_ADDR_RSP, {2'h0, `BFF_RC_UNSUP, `BFF_RS_UNK_CMD});
    rc(`BFF_ADDR_CMD, 34'h55);
    wc(`BFF_ADDR_SET, 32'h0, `BFF_AXI_OKAY);
    rc(`BFF_ADDR_SET, 34'h8);
    wc(8'h40, 32'h10, `BFF_AXI_SLVERR);
    rc(8'h40, {`BFF_AXI_SLVERR, 32'h0});
    wc(`BFF_ADDR_CMD, 32'h11, `BFF_AXI_OKAY);
    frm(fr(5), 1'b1);
    rc(`BFF_ADDR_STAT, 34'h000000f00);
    repeat (4) @(posedge c);
    summarize();
  end
endmodule : testbench
bind bff_filter bff_filter_chk bff_filter_chk_inst (.i_clk_sys, .i_nrst, .i_awvalid, .o_awready, .i_wvalid,
  .o_wready, .o_bvalid, .i_arvalid, .o_arready, .i_araddr, .o_rvalid, .o_rdata, .o_rresp, .i_frm_valid, .i_frm,
  .o_dec_valid, .o_dec_fwd, .o_dec_bcast);
